/* File: logic/hsf_top.v */
// hsf_top.v: heater supervisor; state machine, relays, leds, parameter
// registers on an ahb-lite slave. assumes pins are asynchronous to hclk,
// the nv store ports are on hclk, and one ahb master with hready looped.
// How it works
// - two series relays; safety path opens one
// - processor failure after its first heartbeat makes safety path cut power
// - no power without jacket; flag error
// - starts control on its own after power
// - defaults 150, 260, 20 above, 20 band
// - bus-writable parameters, saved to nv store
// - defaults return only on restore command
// - cold start: violet, then dark, then run
// - voltage mismatch: yellow both, power off
// - below range shows solid blue status
// - in range shows solid green status
// - above high alert shows solid red
// - over safety limit: alarm, flashing red
// - normal keeps control; alerts self-clear
// - lock halts control, opens relays, waits user
// - fatal state only cleared by power cycle
// - standby entered by command only; left by command or watchdog failure
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "hsf_map.vh"

module hsf_top #(
	parameter VIOLET_CYC = `HSF_VIOLET_MS * `HSF_CLK_KHZ,
	parameter DARK_CYC = `HSF_DARK_MS * `HSF_CLK_KHZ,
	parameter BLINK_CYC = `HSF_BLINK_MS * `HSF_CLK_KHZ,
	parameter WD_CYC = `HSF_WD_MS * `HSF_CLK_KHZ
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout_q,
	output reg hresp_q,
	output reg [31:0] hrdata_q,
	// sensing pins
	input wire [`HSF_TW-1:0] temp_pin,
	input wire [1:0] supply_code_pin,
	input wire [1:0] jacket_code_pin,
	input wire jacket_present_pin,
	// non-volatile parameter store
	input wire nv_valid,
	input wire [4*`HSF_TW-1:0] nv_rd_data,
	output reg nv_wr_q,
	output reg [4*`HSF_TW-1:0] nv_wr_data_q,
	// relays, high = closed
	output reg ctrl_relay_q,
	output reg safety_relay_q,
	// leds {red, green, blue}
	output reg [2:0] status_led_q,
	output reg [2:0] diag_led_q
);
	localparam TW = `HSF_TW;

	reg [TW+4:0] sync1_q, sync2_q;
	reg [2:0] state_q, state_d;
	reg [23:0] cnt_q;
	reg [23:0] blink_cnt_q;
	reg blink_q;
	reg [TW-1:0] setpoint_q, limit_q, high_q, low_q;
	reg save_q, loaded_q;
	reg wr_pend_q;
	reg [7:0] wr_addr_q;
	reg [31:0] rd_mux;
	reg [2:0] stat_d, diag_d;
	reg kick_q, standby_q, resume_q, release_q;
	wire trip, wd_fail;

	// two-stage synchroniser; only stage two is read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= {(TW+5){1'b0}};
			sync2_q <= {(TW+5){1'b0}};
		end else begin
			sync1_q <= {jacket_present_pin, jacket_code_pin,
				supply_code_pin, temp_pin};
			sync2_q <= sync1_q;
		end
	end

	wire [TW-1:0] temp = sync2_q[TW-1:0];
	wire mismatch = sync2_q[TW+1:TW] != sync2_q[TW+3:TW+2];
	wire missing = !sync2_q[TW+4];

	// temperature class: 0 low, 1 in range, 2 high alert, 3 safety alarm
	function [1:0] temp_class;
		input [TW-1:0] t, sp, lim, hi, lo;
		reg [TW:0] hi_th, lo_th;
		begin
			hi_th = {1'b0, sp} + {1'b0, hi};
			lo_th = (sp > lo) ? {1'b0, sp - lo} : {(TW+1){1'b0}};
			if (t > lim)
				temp_class = 2'h3;
			else if ({1'b0, t} > hi_th)
				temp_class = 2'h2;
			else if ({1'b0, t} >= lo_th)
				temp_class = 2'h1;
			else
				temp_class = 2'h0;
		end
	endfunction

	wire [1:0] tcls = temp_class(temp, setpoint_q, limit_q, high_q, low_q);
	wire alarm = tcls == 2'h3;

	hsf_safety #(.WD_CYC(WD_CYC)) u_safety (
		.hclk(hclk),
		.hresetn(hresetn),
		.temp(temp),
		.limit(limit_q),
		.kick(kick_q),
		.trip_q(trip),
		.wd_fail_q(wd_fail)
	);

	// ahb address phase
	wire take = hsel && hready && htrans[1];

	always @* begin
		case (haddr[7:0])
		`HSF_REG_SETPOINT: rd_mux = {22'h0, setpoint_q};
		`HSF_REG_LIMIT: rd_mux = {22'h0, limit_q};
		`HSF_REG_HIGH: rd_mux = {22'h0, high_q};
		`HSF_REG_LOW: rd_mux = {22'h0, low_q};
		`HSF_REG_STATUS: rd_mux = {20'h0, safety_relay_q, ctrl_relay_q,
			trip, wd_fail, alarm, tcls == 2'h2, tcls == 2'h0,
			missing, mismatch, state_q};
		`HSF_REG_TEMP: rd_mux = {22'h0, temp};
		default: rd_mux = 32'h00000000;
		endcase
	end

	// zero wait states: read data is latched at the address phase edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			if (hready) begin
				wr_pend_q <= take && hwrite;
				wr_addr_q <= haddr[7:0];
				if (take && !hwrite)
					hrdata_q <= rd_mux;
			end
		end
	end

	wire wr_cmd = wr_pend_q && wr_addr_q == `HSF_REG_CMD;
	wire restore = wr_cmd && hwdata[`HSF_CMD_DEFAULTS];

	// parameters: reset loads defaults, then the nv copy once at start
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setpoint_q <= `HSF_DEF_SETPOINT;
			limit_q <= `HSF_DEF_LIMIT;
			high_q <= `HSF_DEF_HIGH;
			low_q <= `HSF_DEF_LOW;
			save_q <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			save_q <= 1'b0;
			if (save_q)
				loaded_q <= 1'b1; // a late store copy is stale by now
			else if (!loaded_q && nv_valid) begin
				loaded_q <= 1'b1;
				{setpoint_q, limit_q, high_q, low_q} <= nv_rd_data;
			end
			if (restore) begin
				setpoint_q <= `HSF_DEF_SETPOINT;
				limit_q <= `HSF_DEF_LIMIT;
				high_q <= `HSF_DEF_HIGH;
				low_q <= `HSF_DEF_LOW;
				save_q <= 1'b1;
			end else if (wr_pend_q) begin
				case (wr_addr_q)
				`HSF_REG_SETPOINT: setpoint_q <= hwdata[TW-1:0];
				`HSF_REG_LIMIT: limit_q <= hwdata[TW-1:0];
				`HSF_REG_HIGH: high_q <= hwdata[TW-1:0];
				`HSF_REG_LOW: low_q <= hwdata[TW-1:0];
				default: ;
				endcase
				save_q <= wr_addr_q != `HSF_REG_CMD &&
					wr_addr_q <= `HSF_REG_LOW;
			end
		end
	end

	// nv write pulse follows the parameter update by one cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nv_wr_q <= 1'b0;
			nv_wr_data_q <= {(4*TW){1'b0}};
		end else begin
			nv_wr_q <= save_q;
			if (save_q)
				nv_wr_data_q <= {setpoint_q, limit_q, high_q, low_q};
		end
	end

	// command and heartbeat pulses
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			kick_q <= 1'b0;
			standby_q <= 1'b0;
			resume_q <= 1'b0;
			release_q <= 1'b0;
		end else begin
			kick_q <= wr_pend_q && wr_addr_q == `HSF_REG_KICK;
			standby_q <= wr_cmd && hwdata[`HSF_CMD_STANDBY];
			resume_q <= wr_cmd && hwdata[`HSF_CMD_RESUME];
			release_q <= wr_cmd && hwdata[`HSF_CMD_RELEASE];
		end
	end

	wire cnt_done = (state_q == `HSF_ST_VIOLET) ?
		cnt_q == VIOLET_CYC[23:0] - 24'h000001 :
		cnt_q == DARK_CYC[23:0] - 24'h000001;

	always @* begin
		state_d = state_q;
		case (state_q)
		`HSF_ST_VIOLET: if (cnt_done) state_d = `HSF_ST_DARK;
		`HSF_ST_DARK: if (cnt_done) state_d = `HSF_ST_CHECK;
		`HSF_ST_CHECK: begin
			if (!missing && !mismatch)
				state_d = `HSF_ST_NORMAL;
		end
		`HSF_ST_NORMAL: begin
			if (alarm)
				state_d = `HSF_ST_LOCK;
			else if (standby_q)
				state_d = `HSF_ST_STANDBY;
			else if (missing || mismatch)
				state_d = `HSF_ST_CHECK;
		end
		`HSF_ST_LOCK: begin
			if (release_q && !alarm)
				state_d = `HSF_ST_CHECK;
		end
		`HSF_ST_STANDBY: if (resume_q) state_d = `HSF_ST_CHECK;
		`HSF_ST_FATAL: state_d = `HSF_ST_FATAL;
		default: state_d = `HSF_ST_FATAL;
		endcase
		if (wd_fail)
			state_d = `HSF_ST_FATAL;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= `HSF_ST_VIOLET;
			cnt_q <= 24'h000000;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_d != state_q) ? 24'h000000 :
				cnt_q + 24'h000001;
		end
	end

	// free blink timer for flashing red
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_cnt_q <= 24'h000000;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == BLINK_CYC[23:0] - 24'h000001) begin
			blink_cnt_q <= 24'h000000;
			blink_q <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 24'h000001;
		end
	end

	// led colours follow state and live temperature class, so alerts
	// clear by themselves once the temperature moves back
	always @* begin
		stat_d = `HSF_RGB_DARK;
		diag_d = `HSF_RGB_DARK;
		case (state_q)
		`HSF_ST_VIOLET: begin
			stat_d = `HSF_RGB_VIOLET;
			diag_d = `HSF_RGB_VIOLET;
		end
		`HSF_ST_CHECK: begin
			if (mismatch) begin
				stat_d = `HSF_RGB_YELLOW;
				diag_d = `HSF_RGB_YELLOW;
			end else if (missing)
				diag_d = `HSF_RGB_RED;
		end
		`HSF_ST_NORMAL: begin
			case (tcls)
			2'h0: stat_d = `HSF_RGB_BLUE;
			2'h1: stat_d = `HSF_RGB_GREEN;
			2'h2: stat_d = `HSF_RGB_RED;
			default: stat_d = blink_q ? `HSF_RGB_RED : `HSF_RGB_DARK;
			endcase
			diag_d = (tcls == 2'h1) ? `HSF_RGB_GREEN : `HSF_RGB_BLUE;
		end
		`HSF_ST_LOCK: begin
			stat_d = blink_q ? `HSF_RGB_RED : `HSF_RGB_DARK;
			diag_d = `HSF_RGB_RED;
		end
		`HSF_ST_FATAL: begin
			stat_d = `HSF_RGB_RED;
			diag_d = `HSF_RGB_RED;
		end
		`HSF_ST_STANDBY: diag_d = `HSF_RGB_GREEN;
		default: ;
		endcase
	end

	// relays close only in normal; control relay does on/off regulation
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_relay_q <= 1'b0;
			safety_relay_q <= 1'b0;
			status_led_q <= `HSF_RGB_DARK;
			diag_led_q <= `HSF_RGB_DARK;
		end else begin
			status_led_q <= stat_d;
			diag_led_q <= diag_d;
			if (state_d == `HSF_ST_NORMAL && !missing && !mismatch) begin
				ctrl_relay_q <= temp < setpoint_q;
				safety_relay_q <= !trip;
			end else begin
				ctrl_relay_q <= 1'b0;
				safety_relay_q <= 1'b0;
			end
		end
	end
endmodule

/* File: logic/hsf_map.vh */
// hsf_map.vh: offsets, field positions, reset values and timing counts
// for the heater supervisor; included by every design file of the block.
`ifndef HSF_MAP_VH
`define HSF_MAP_VH

// bus register byte offsets
`define HSF_REG_CMD 8'h00
`define HSF_REG_SETPOINT 8'h04
`define HSF_REG_LIMIT 8'h08
`define HSF_REG_HIGH 8'h0C
`define HSF_REG_LOW 8'h10
`define HSF_REG_STATUS 8'h14
`define HSF_REG_KICK 8'h18
`define HSF_REG_TEMP 8'h1C

// command register bits (write one to act)
`define HSF_CMD_STANDBY 0
`define HSF_CMD_RESUME 1
`define HSF_CMD_DEFAULTS 2
`define HSF_CMD_RELEASE 3

// factory defaults, degrees C
`define HSF_TW 10
`define HSF_DEF_SETPOINT 10'h096
`define HSF_DEF_LIMIT 10'h104
`define HSF_DEF_HIGH 10'h014
`define HSF_DEF_LOW 10'h014

// states
`define HSF_ST_VIOLET 3'h0
`define HSF_ST_DARK 3'h1
`define HSF_ST_CHECK 3'h2
`define HSF_ST_NORMAL 3'h3
`define HSF_ST_LOCK 3'h4
`define HSF_ST_FATAL 3'h5
`define HSF_ST_STANDBY 3'h6

// led colours {red, green, blue}
`define HSF_RGB_DARK 3'h0
`define HSF_RGB_BLUE 3'h1
`define HSF_RGB_GREEN 3'h2
`define HSF_RGB_YELLOW 3'h6
`define HSF_RGB_RED 3'h4
`define HSF_RGB_VIOLET 3'h5

// timing: clock rate and times in milliseconds
`define HSF_CLK_KHZ 25000
`define HSF_VIOLET_MS 500
`define HSF_DARK_MS 500
`define HSF_BLINK_MS 250
`define HSF_WD_MS 1000

`endif

/* File: logic/hsf_safety.v */
// hsf_safety.v: independent safety path; watchdog on processor heartbeat
// and over-temperature trip. assumes temp is already synchronised.
`timescale 1ns/1ns
`include "hsf_map.vh"

module hsf_safety #(
	parameter WD_CYC = `HSF_WD_MS * `HSF_CLK_KHZ
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// monitored values
	input wire [`HSF_TW-1:0] temp,
	input wire [`HSF_TW-1:0] limit,
	input wire kick,
	// trip outputs
	output reg trip_q,
	output reg wd_fail_q
);
	reg armed_q;
	reg [24:0] wd_cnt_q;
	wire [24:0] wd_top = WD_CYC[24:0] - 25'h0000001;

	// watchdog arms on first heartbeat so a board with no software still
	// runs; once it fails it stays failed until power is cycled
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_q <= 1'b0;
			wd_cnt_q <= 25'h0000000;
			wd_fail_q <= 1'b0;
		end else begin
			if (kick) begin
				armed_q <= 1'b1;
				wd_cnt_q <= 25'h0000000;
			end else if (armed_q && !wd_fail_q) begin
				if (wd_cnt_q == wd_top)
					wd_fail_q <= 1'b1;
				else
					wd_cnt_q <= wd_cnt_q + 25'h0000001;
			end
		end
	end

	// this path can only open the safety relay, never close it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			trip_q <= 1'b0;
		else
			trip_q <= wd_fail_q || (temp > limit);
	end
endmodule

/* File: bench/hsf_checker.sv */
// hsf_checker.sv: pin-level assertions for the heater supervisor.
// assumes leds coded {red, green, blue} and the bind at the foot.
`timescale 1ns/1ns
`include "hsf_map.vh"

module hsf_checker (
	// clock and reset
	input logic hclk,
	input logic hresetn,
	// watched outputs
	input logic hreadyout_q,
	input logic hresp_q,
	input logic nv_wr_q,
	input logic ctrl_relay_q,
	input logic safety_relay_q,
	input logic [2:0] status_led_q,
	input logic [2:0] diag_led_q
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire off = !ctrl_relay_q && !safety_relay_q;
	wire vio = status_led_q == `HSF_RGB_VIOLET;
	wire yel = status_led_q == `HSF_RGB_YELLOW;
	wire redd = diag_led_q == `HSF_RGB_RED;
	sequence vio_end;
		vio ##1 !vio;
	endsequence
	sequence yel_two;
		yel [*2];
	endsequence
	sequence red_two;
		redd [*2];
	endsequence
	bus_okay_a:
		assert property (hreadyout_q && !hresp_q)
		else $error("bus not ready or not okay");
	violet_both_a:
		assert property (vio |-> diag_led_q == `HSF_RGB_VIOLET)
		else $error("violet on one led set only");
	violet_dark_a:
		assert property (vio_end |-> status_led_q == 3'h0 && diag_led_q == 3'h0)
		else $error("violet not followed by dark");
	violet_open_a:
		assert property (vio |-> off)
		else $error("relay closed during start");
	yellow_open_a:
		assert property (yel_two |-> $past(off) && diag_led_q == 3'h6)
		else $error("mismatch without both yellow and power off");
	red_diag_open_a:
		assert property (red_two |-> $past(off))
		else $error("relay closed under red diag");
	green_pair_a:
		assert property (status_led_q == 3'h2 |-> diag_led_q == 3'h2)
		else $error("green status without green diag");
	nv_pulse_a:
		assert property (nv_wr_q |=> !nv_wr_q)
		else $error("store strobe longer than one cycle");
endmodule

bind hsf_top hsf_checker chk (.hclk, .hresetn, .hreadyout_q, .hresp_q,
	.nv_wr_q, .ctrl_relay_q, .safety_relay_q, .status_led_q, .diag_led_q);

/* File: bench/hsf_jacket.sv */
// hsf_jacket.sv: jacket sensor that warms slowly, and the nv store.
// assumes the store keeps its contents through a reset.
`timescale 1ns/1ns

module hsf_jacket (
	// clock
	input logic hclk,
	// sensor
	input logic [9:0] goal,
	output logic [9:0] temp_pin,
	// store
	input logic nv_wr_q,
	input logic [39:0] nv_wr_data_q,
	output logic nv_valid,
	output logic [39:0] nv_rd_data
);
	initial begin
		temp_pin = 10'h019;
		nv_valid = 1'b0;
		nv_rd_data = 40'h0;
	end
	// one degree a clock, so every band is crossed on the way
	always @(posedge hclk) begin
		if (temp_pin < goal)
			temp_pin <= temp_pin + 10'h001;
		else if (temp_pin > goal)
			temp_pin <= temp_pin - 10'h001;
	end
	always @(posedge hclk) begin
		if (nv_wr_q) begin
			nv_valid <= 1'b1;
			nv_rd_data <= nv_wr_data_q;
		end
	end
endmodule

/* File: bench/tb_heater_supervisor_fsm.sv */
// tb_heater_supervisor_fsm.sv: self-checking bench for the supervisor.
// assumes hsf_top, hsf_jacket and the bound checker; leds {r,g,b}.
`timescale 1ns/1ns

module tb_heater_supervisor_fsm;
	logic hclk, hresetn, hsel, hwrite, hreadyout_q, hresp_q;
	logic pres, nv_wr_q, nv_valid, crl, srl;
	logic [31:0] haddr, hwdata, hrdata_q, r;
	logic [1:0] htrans, sup, jc;
	logic [2:0] hsize, st, dg;
	logic [9:0] goal, temp_pin;
	logic [39:0] nv_rd, nv_wd;
	int n_errors, checked;

	// short counts keep the run brief
	hsf_top #(.VIOLET_CYC(8), .DARK_CYC(8), .BLINK_CYC(4), .WD_CYC(64)) uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout_q), .hreadyout_q, .hresp_q, .hrdata_q, .temp_pin,
		.supply_code_pin(sup), .jacket_code_pin(jc), .jacket_present_pin(pres),
		.nv_valid, .nv_rd_data(nv_rd), .nv_wr_q, .nv_wr_data_q(nv_wd),
		.ctrl_relay_q(crl), .safety_relay_q(srl), .status_led_q(st),
		.diag_led_q(dg));
	hsf_jacket jack (.hclk, .goal, .temp_pin, .nv_wr_q,
		.nv_wr_data_q(nv_wd), .nv_valid, .nv_rd_data(nv_rd));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task conclude;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input [31:0] e, input [31:0] s, input string nm);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout_q !== 1'b1 && n < 50);
		if (hreadyout_q !== 1'b1) begin
			n_errors++;
			$display("[FAIL] bus ready exp 1 got %b", hreadyout_q);
			conclude;
		end
	endtask

	task bus(input [7:0] a, input w, input [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata_q;
	endtask

	task rdc(input [7:0] a, input [31:0] e, m, input string nm);
		bus(a, 1'b0, 32'h0);
		chk(e, r & m, nm);
	endtask

	task wst(input [2:0] e, input int lim);
		int n;
		n = 0;
		while (st !== e && n < lim) begin
			@(posedge hclk);
			n++;
		end
		chk(e, st, "status led");
		if (st !== e)
			conclude;
	endtask

	// ramp the jacket, then allow for the pin synchronisers
	task heat(input [9:0] t);
		int n;
		goal <= t;
		n = 0;
		while (temp_pin !== t && n < 400) begin
			@(posedge hclk);
			n++;
		end
		if (temp_pin !== t) begin
			n_errors++;
			$display("[FAIL] jacket temp exp %h got %h", t, temp_pin);
			conclude;
		end
		cyc(4);
	endtask

	task do_reset;
		hresetn <= 1'b0;
		cyc(6);
		hresetn <= 1'b1;
	endtask

	task boot;
		do_reset;
		wst(3'h5, 4);
		chk(3'h5, dg, "diag violet");
		wst(3'h0, 12);
		wst(3'h1, 30);
		chk(2'h3, {crl, srl}, "relays");
		$display("end boot");
	endtask

	task bands;
		static logic [9:0] t[5] = '{10'h082, 10'h081, 10'h0AA, 10'h0AB,
			10'h08C};
		static logic [2:0] e[5] = '{3'h2, 3'h1, 3'h2, 3'h4, 3'h2};
		for (int i = 0; i < 5; i++) begin
			heat(t[i]);
			chk(e[i], st, "band led");
		end
		chk(1'b1, crl, "ctrl relay");
		$display("end bands");
	endtask

	task lock;
		logic [1:0] seen;
		heat(10'h105);
		rdc(8'h14, 32'h84, 32'hC87, "lock");
		seen = 2'h0;
		repeat (10) begin
			@(posedge hclk);
			seen = seen | {st == 3'h4, st == 3'h0};
		end
		chk(2'h3, seen, "flash");
		bus(8'h00, 1'b1, 32'h8);
		cyc(3);
		rdc(8'h14, 32'h4, 32'h7, "hot release");
		heat(10'h08C);
		rdc(8'h14, 32'h4, 32'h7, "cool locked");
		bus(8'h00, 1'b1, 32'h8);
		wst(3'h2, 20);
		$display("end lock");
	endtask

	task pins;
		jc <= 2'h1;
		cyc(8);
		chk(3'h6, st, "mismatch led");
		rdc(8'h14, 32'h8, 32'hC08, "mismatch");
		jc <= 2'h0;
		pres <= 1'b0;
		cyc(8);
		rdc(8'h14, 32'h10, 32'hC10, "missing");
		pres <= 1'b1;
		wst(3'h2, 20);
		$display("end pins");
	endtask

	task standby;
		bus(8'h00, 1'b1, 32'h1);
		cyc(3);
		rdc(8'h14, 32'h6, 32'hC07, "standby");
		heat(10'h0A0);
		rdc(8'h14, 32'h6, 32'h7, "idle");
		bus(8'h00, 1'b1, 32'h2);
		wst(3'h2, 20);
		$display("end standby");
	endtask

	task params;
		static logic [9:0] d[4] = '{10'h096, 10'h104, 10'h014, 10'h014};
		for (int i = 0; i < 4; i++)
			rdc(8'(4 * i + 4), {22'h0, d[i]}, '1, "default");
		for (int i = 0; i < 4; i++)
			bus(8'(4 * i + 4), 1'b1, {22'h0, d[i] + 10'h001});
		cyc(4);
		do_reset;
		wst(3'h2, 40);
		for (int i = 0; i < 4; i++)
			rdc(8'(4 * i + 4), {22'h0, d[i] + 10'h001}, '1, "kept");
		bus(8'h00, 1'b1, 32'h4);
		cyc(3);
		for (int i = 0; i < 4; i++)
			rdc(8'(4 * i + 4), {22'h0, d[i]}, '1, "restored");
		rdc(8'h20, 32'h0, '1, "unmapped");
		$display("end params");
	endtask

	task fatal;
		bus(8'h18, 1'b1, 32'h0);
		cyc(80);
		chk(3'h4, dg, "fatal diag");
		chk(1'b0, srl, "safety relay");
		bus(8'h00, 1'b1, 32'hA);
		cyc(3);
		rdc(8'h14, 32'h105, 32'h107, "fatal");
		$display("end fatal");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sup = 2'h0;
		jc = 2'h0;
		pres = 1'b1;
		goal = 10'h019;
		n_errors = 0;
		checked = 0;
		boot;
		bands;
		lock;
		pins;
		standby;
		params;
		fatal;
		conclude;
	end
endmodule
